// >>> rtl/pmwc_ctrl.sv
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Sleep wakes to active on any interrupt enabled in the core controller.
// - Deep modes: pin interrupt wakes only if core and pin start enables set.
// - Brown-out interrupt wakes deep modes with all three enables and detector powered.
// - Brown-out reset wakes deep modes when reset enabled and detector powered.
// - Watchdog interrupt wakes deep modes when running, enabled everywhere, oscillator powered.
// - Watchdog reset wakes deep modes when running, reset enabled, oscillator powered.
// - Deep power-down wakes only on dedicated pins enabled in wake pin enable.
// - Power mode field resets to zero; then wait gives plain core sleep.
// - Power mode one makes wait enter deep-sleep.
// - Power mode two makes wait enter power-down.
// - Power mode three makes the sleep request enter deep power-down.
// - Power control at offset zero selects mode and reports entry flags.
// - Five read-write scratch words at offsets four to twenty, reset zero.
// - Wake pin status reads at 0x020, write one clears a bit, resets to zero.
// - Wake pin enable reads and writes at 0x024, resets to zero.
// - Core deep sleep select picks core sleep or a system low-power state.
// - Deep power-down block bit sticks at one until power-on reset.
// - Sleep flag sets on sleep-class entry; write one clears it.
// - Deep power-down flag sets on entry; write one clears it.
module pmwc_ctrl
  import pmwc_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic en_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic wfi_i,
  input wire logic deep_sleep_select_i,
  input wire logic [IRQ_W-1:0] core_irq_i,
  input wire logic [IRQ_W-1:0] core_irq_en_i,
  input wire pmwc_wake_t wake_src_i,
  input wire logic [PIN_W-1:0] wake_pin_n_i,
  output pmwc_state_t mode_o,
  output pmwc_gate_t gate_o,
  output logic wake_o,
  output logic sys_reset_req_o
);

  typedef struct packed {
    pmwc_state_t mode;
    logic [PM_W-1:0] pm;
    logic deep_powerdown_block;
    logic sleep_flag;
    logic dpd_flag;
    logic [NUM_SCRATCH-1:0][DATA_W-1:0] scratch;
    logic [PIN_W-1:0] pin_status;
    logic [PIN_W-1:0] pin_enable;
    logic [PIN_W-1:0] pin_prev;
    logic [DATA_W-1:0] rdata;
    logic wake;
    logic rst_req;
    pmwc_gate_t gate;
  } pmwc_regs_t;

  pmwc_regs_t s;
  pmwc_regs_t next_s;
  logic [PIN_W-1:0] pin_fall;
  logic deep_wake;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // Deep-sleep and power-down wake qualification
  function automatic logic deep_wake_of(input pmwc_wake_t w);
    logic pin_w;
    logic bod_w;
    logic wdt_w;
    logic other_w;
    pin_w = |(w.pin_irq & w.pin_core_interrupt_controller_en & w.pin_start);
    bod_w = (w.bod_irq & w.bod_core_interrupt_controller_en & w.bod_start & w.bod_irq_en & w.bod_powered)
      | (w.bod_rst & w.bod_rst_en & w.bod_powered);
    wdt_w = (w.wdt_irq & w.wdt_core_interrupt_controller_en & w.wdt_start & w.wdt_running & w.wdt_irq_en
      & w.low_power_oscillator_powered)
      | (w.wdt_rst & w.wdt_running & w.wdt_rst_en & w.low_power_oscillator_powered);
    // Timer and serial wake rely on software and the far end having set them up
    other_w = (w.wkt_irq & w.wkt_core_interrupt_controller_en & w.wkt_start)
      | (w.ser_irq & w.ser_core_interrupt_controller_en & w.ser_start);
    deep_wake_of = pin_w | bod_w | wdt_w | other_w;
  endfunction

  assign pin_fall = s.pin_prev & ~wake_pin_n_i;
  assign deep_wake = deep_wake_of(wake_src_i);

  always_comb begin
    next_s = s;
    next_s.wake = 1'b0;
    next_s.rst_req = 1'b0;
    next_s.rdata = WORD_RESET;
    next_s.pin_prev = wake_pin_n_i;

    if (wr_i) begin
      if (hit(addr_i, POWER_CONTROL_OFF)) begin
        next_s.pm = wdata_i[PM_LSB +: PM_W];
        if (wdata_i[DEEP_POWERDOWN_BLOCK_BIT]) begin
          next_s.deep_powerdown_block = 1'b1;
        end
        if (wdata_i[SLEEP_FLAG_BIT]) begin
          next_s.sleep_flag = 1'b0;
        end
        if (wdata_i[DPD_FLAG_BIT]) begin
          next_s.dpd_flag = 1'b0;
        end
      end
      for (int i = 0; i < NUM_SCRATCH; i++) begin
        if (hit(addr_i, SCRATCH_OFF[i])) begin
          next_s.scratch[i] = wdata_i;
        end
      end
      if (hit(addr_i, WAKE_PIN_STATUS_OFF)) begin
        next_s.pin_status = s.pin_status & ~wdata_i[PIN_W-1:0];
      end
      if (hit(addr_i, WAKE_PIN_ENABLE_OFF)) begin
        next_s.pin_enable = wdata_i[PIN_W-1:0];
      end
    end
    // A falling pin edge in the clearing cycle is kept
    next_s.pin_status = next_s.pin_status | pin_fall;

    if (rd_i) begin
      if (hit(addr_i, POWER_CONTROL_OFF)) begin
        next_s.rdata[PM_LSB +: PM_W] = s.pm;
        next_s.rdata[DEEP_POWERDOWN_BLOCK_BIT] = s.deep_powerdown_block;
        next_s.rdata[SLEEP_FLAG_BIT] = s.sleep_flag;
        next_s.rdata[DPD_FLAG_BIT] = s.dpd_flag;
      end
      for (int i = 0; i < NUM_SCRATCH; i++) begin
        if (hit(addr_i, SCRATCH_OFF[i])) begin
          next_s.rdata = s.scratch[i];
        end
      end
      if (hit(addr_i, WAKE_PIN_STATUS_OFF)) begin
        next_s.rdata[PIN_W-1:0] = s.pin_status;
      end
      if (hit(addr_i, WAKE_PIN_ENABLE_OFF)) begin
        next_s.rdata[PIN_W-1:0] = s.pin_enable;
      end
    end

    case (s.mode)
      ST_ACTIVE: begin
        if (wfi_i) begin
          next_s.sleep_flag = 1'b1;
          if (!deep_sleep_select_i) begin
            next_s.mode = ST_SLEEP;
          end else begin
            case (s.pm)
              PM_DSLEEP: next_s.mode = ST_DSLEEP;
              PM_PDOWN: next_s.mode = ST_PDOWN;
              PM_DPD: begin
                // Blocked deep power-down falls back to core sleep
                if (!s.deep_powerdown_block) begin
                  next_s.mode = ST_DPD;
                  // A sleep flag clear written in the entry cycle must still land
                  next_s.sleep_flag = s.sleep_flag
                    && !(wr_i && hit(addr_i, POWER_CONTROL_OFF) && wdata_i[SLEEP_FLAG_BIT]);
                  next_s.dpd_flag = 1'b1;
                end else begin
                  next_s.mode = ST_SLEEP;
                end
              end
              default: next_s.mode = ST_SLEEP;
            endcase
          end
        end
      end
      ST_SLEEP: begin
        if (|(core_irq_i & core_irq_en_i)) begin
          next_s.mode = ST_ACTIVE;
          next_s.wake = 1'b1;
        end
      end
      ST_DSLEEP, ST_PDOWN: begin
        if (deep_wake) begin
          next_s.mode = ST_ACTIVE;
          next_s.wake = 1'b1;
        end
      end
      ST_DPD: begin
        // Only enabled dedicated pins count here; all other sources are off
        if (|(pin_fall & s.pin_enable)) begin
          next_s.mode = ST_REBOOT;
          next_s.rst_req = 1'b1;
        end
      end
      ST_REBOOT: begin
        next_s.mode = ST_ACTIVE;
        next_s.wake = 1'b1;
      end
      default: next_s.mode = ST_ACTIVE;
    endcase

    next_s.gate.core_clk_off = (next_s.mode != ST_ACTIVE) && (next_s.mode != ST_REBOOT);
    next_s.gate.sys_clk_off = (next_s.mode == ST_DSLEEP) || (next_s.mode == ST_PDOWN)
      || (next_s.mode == ST_DPD);
    next_s.gate.flash_off = (next_s.mode == ST_PDOWN) || (next_s.mode == ST_DPD);
    next_s.gate.deep_pd = (next_s.mode == ST_DPD);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.mode <= ST_ACTIVE;
      s.pm <= PM_RESET;
      s.pin_prev <= PIN_IDLE;
    end else if (en_i) begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
  assign mode_o = s.mode;
  assign gate_o = s.gate;
  assign wake_o = s.wake;
  assign sys_reset_req_o = s.rst_req;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_sleep_wake;
    en_i && s.mode == ST_SLEEP && |(core_irq_i & core_irq_en_i) |=> s.mode == ST_ACTIVE && wake_o;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep did not wake");

  property p_deep_pin_hold;
    en_i && s.mode == ST_DSLEEP && !deep_wake |=> s.mode == ST_DSLEEP;
  endproperty
  a_deep_pin_hold: assert property (p_deep_pin_hold) else $error("deep-sleep left unqualified");

  property p_bod_wake;
    en_i && s.mode == ST_PDOWN && wake_src_i.bod_rst && wake_src_i.bod_rst_en
      && wake_src_i.bod_powered |=> s.mode == ST_ACTIVE;
  endproperty
  a_bod_wake: assert property (p_bod_wake) else $error("brown-out reset did not wake");

  property p_wdt_wake;
    en_i && s.mode == ST_DSLEEP && wake_src_i.wdt_rst && wake_src_i.wdt_running
      && wake_src_i.wdt_rst_en && wake_src_i.low_power_oscillator_powered |=> wake_o;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog reset did not wake");

  property p_dpd_pin;
    en_i && s.mode == ST_DPD && |(pin_fall & s.pin_enable)
      |=> sys_reset_req_o ##1 (!en_i || s.mode == ST_ACTIVE);
  endproperty
  a_dpd_pin: assert property (p_dpd_pin) else $error("pin did not leave deep power-down");

  property p_dpd_only_pin;
    s.mode == ST_DPD && $past(s.mode) == ST_DPD |-> !sys_reset_req_o && !wake_o;
  endproperty
  a_dpd_only_pin: assert property (p_dpd_only_pin) else $error("deep power-down left early");

  property p_enter_mode;
    en_i && s.mode == ST_ACTIVE && wfi_i && deep_sleep_select_i && s.pm == PM_DSLEEP
      |=> s.mode == ST_DSLEEP && gate_o.sys_clk_off && !gate_o.flash_off;
  endproperty
  a_enter_mode: assert property (p_enter_mode) else $error("deep-sleep not entered");

  property p_enter_pdown;
    en_i && s.mode == ST_ACTIVE && wfi_i && deep_sleep_select_i && s.pm == PM_PDOWN
      |=> s.mode == ST_PDOWN && gate_o.flash_off;
  endproperty
  a_enter_pdown: assert property (p_enter_pdown) else $error("power-down not entered");

  property p_core_sleep;
    en_i && s.mode == ST_ACTIVE && wfi_i && (!deep_sleep_select_i || s.pm == PM_ACTIVE)
      |=> s.mode == ST_SLEEP && !gate_o.sys_clk_off;
  endproperty
  a_core_sleep: assert property (p_core_sleep) else $error("plain sleep not entered");

  property p_deep_powerdown_block_block;
    en_i && s.deep_powerdown_block && wfi_i && s.mode == ST_ACTIVE |=> s.mode != ST_DPD && s.deep_powerdown_block;
  endproperty
  a_deep_powerdown_block_block: assert property (p_deep_powerdown_block_block) else $error("deep power-down not blocked");

  property p_dpd_flag;
    en_i && s.mode == ST_ACTIVE && next_s.mode == ST_DPD |=> s.dpd_flag
      ##1 (s.dpd_flag || $past(wr_i && addr_i == POWER_CONTROL_OFF && wdata_i[DPD_FLAG_BIT]));
  endproperty
  a_dpd_flag: assert property (p_dpd_flag) else $error("deep power-down flag missing");

  property p_scratch_kept;
    s.mode == ST_DPD && !wr_i ##1 s.mode == ST_REBOOT |-> $stable(s.scratch);
  endproperty
  a_scratch_kept: assert property (p_scratch_kept) else $error("scratch lost on reboot");

  property p_bod_irq_wake;
    en_i && s.mode == ST_DSLEEP && wake_src_i.bod_irq && wake_src_i.bod_core_interrupt_controller_en && wake_src_i.bod_start
      && wake_src_i.bod_irq_en && wake_src_i.bod_powered |=> s.mode == ST_ACTIVE && wake_o;
  endproperty
  a_bod_irq_wake: assert property (p_bod_irq_wake) else $error("brown-out irq did not wake");

  property p_wdt_irq_wake;
    en_i && s.mode == ST_PDOWN && wake_src_i.wdt_irq && wake_src_i.wdt_core_interrupt_controller_en && wake_src_i.wdt_start
      && wake_src_i.wdt_running && wake_src_i.wdt_irq_en && wake_src_i.low_power_oscillator_powered |=> wake_o;
  endproperty
  a_wdt_irq_wake: assert property (p_wdt_irq_wake) else $error("watchdog irq did not wake");

  property p_enter_dpd;
    en_i && s.mode == ST_ACTIVE && wfi_i && deep_sleep_select_i && s.pm == PM_DPD && !s.deep_powerdown_block
      |=> s.mode == ST_DPD && gate_o.deep_pd && s.dpd_flag;
  endproperty
  a_enter_dpd: assert property (p_enter_dpd) else $error("deep power-down not entered");

  property p_pm_write;
    en_i && wr_i && addr_i == POWER_CONTROL_OFF |=> s.pm == $past(wdata_i[PM_LSB +: PM_W]);
  endproperty
  a_pm_write: assert property (p_pm_write) else $error("power mode field not written");

  property p_scratch_write;
    en_i && wr_i && addr_i == SCRATCH_OFF[0] |=> s.scratch[0] == $past(wdata_i);
  endproperty
  a_scratch_write: assert property (p_scratch_write) else $error("scratch word not written");

  property p_pin_status_set;
    en_i && |pin_fall |=> (s.pin_status & $past(pin_fall)) == $past(pin_fall);
  endproperty
  a_pin_status_set: assert property (p_pin_status_set) else $error("pin status edge lost");

  property p_pin_enable_write;
    en_i && wr_i && addr_i == WAKE_PIN_ENABLE_OFF |=> s.pin_enable == $past(wdata_i[PIN_W-1:0]);
  endproperty
  a_pin_enable_write: assert property (p_pin_enable_write) else $error("pin enable not written");

  property p_sleep_flag_set;
    en_i && s.mode == ST_ACTIVE && wfi_i && next_s.mode != ST_DPD |=> s.sleep_flag;
  endproperty
  a_sleep_flag_set: assert property (p_sleep_flag_set) else $error("sleep flag not set");

  property p_read_idle;
    en_i && !rd_i |=> rdata_o == WORD_RESET;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside read cycle");

  property p_dpd_no_other;
    en_i && s.mode == ST_DPD && !(|(pin_fall & s.pin_enable)) |=> s.mode == ST_DPD;
  endproperty
  a_dpd_no_other: assert property (p_dpd_no_other) else $error("deep power-down left without pin");

  property p_wake_pulse;
    en_i && wake_o |=> !wake_o;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");

  c_sleep_cycle: cover property (s.mode == ST_SLEEP ##[1:20] s.mode == ST_ACTIVE);
  c_pdown_cycle: cover property (s.mode == ST_PDOWN ##[1:20] wake_o);
  c_dpd_reboot: cover property (s.mode == ST_DPD ##[1:20] sys_reset_req_o);
  c_flag_clear: cover property (s.sleep_flag ##1 !s.sleep_flag);
  c_dsleep_cycle: cover property (s.mode == ST_DSLEEP ##[1:20] wake_o);

endmodule
`default_nettype wire

// >>> rtl/pmwc_pkg.sv
package pmwc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IRQ_W = 32;
  localparam int PIN_W = 8;
  localparam int NUM_SCRATCH = 5;

  // Register offsets
  localparam logic [ADDR_W-1:0] POWER_CONTROL_OFF = 8'h00;
  localparam logic [NUM_SCRATCH-1:0][ADDR_W-1:0] SCRATCH_OFF = {8'h14, 8'h10, 8'h0c, 8'h08, 8'h04};
  localparam logic [ADDR_W-1:0] WAKE_PIN_STATUS_OFF = 8'h20;
  localparam logic [ADDR_W-1:0] WAKE_PIN_ENABLE_OFF = 8'h24;

  // Power control fields
  localparam int PM_LSB = 0;
  localparam int PM_W = 3;
  localparam int DEEP_POWERDOWN_BLOCK_BIT = 3;
  localparam int SLEEP_FLAG_BIT = 8;
  localparam int DPD_FLAG_BIT = 11;

  // Power mode field encodings
  localparam logic [PM_W-1:0] PM_ACTIVE = 3'h0;
  localparam logic [PM_W-1:0] PM_DSLEEP = 3'h1;
  localparam logic [PM_W-1:0] PM_PDOWN = 3'h2;
  localparam logic [PM_W-1:0] PM_DPD = 3'h3;

  // Reset values
  localparam logic [PM_W-1:0] PM_RESET = 3'h0;
  localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
  localparam logic [PIN_W-1:0] PIN_RESET = 8'h00;
  localparam logic [PIN_W-1:0] PIN_IDLE = 8'hff;

  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_SLEEP,
    ST_DSLEEP,
    ST_PDOWN,
    ST_DPD,
    ST_REBOOT
  } pmwc_state_t;

  // Wake sources and their qualifiers from the core, system config and peripherals
  typedef struct packed {
    logic [PIN_W-1:0] pin_irq;
    logic [PIN_W-1:0] pin_core_interrupt_controller_en;
    logic [PIN_W-1:0] pin_start;
    logic bod_irq;
    logic bod_core_interrupt_controller_en;
    logic bod_start;
    logic bod_irq_en;
    logic bod_rst;
    logic bod_rst_en;
    logic bod_powered;
    logic wdt_irq;
    logic wdt_core_interrupt_controller_en;
    logic wdt_start;
    logic wdt_running;
    logic wdt_irq_en;
    logic wdt_rst;
    logic wdt_rst_en;
    logic low_power_oscillator_powered;
    logic wkt_irq;
    logic wkt_core_interrupt_controller_en;
    logic wkt_start;
    logic ser_irq;
    logic ser_core_interrupt_controller_en;
    logic ser_start;
  } pmwc_wake_t;

  // Power gating outputs
  typedef struct packed {
    logic core_clk_off;
    logic sys_clk_off;
    logic flash_off;
    logic deep_pd;
  } pmwc_gate_t;

endpackage

// >>> verif/pmwc_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pmwc_ctrl_tb_top
  import pmwc_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic wait_for_interrupt = 1'b0;
  logic dss = 1'b0;
  logic fire = 1'b0;
  logic drop = 1'b0;
  logic blk_set = 1'b0;
  logic [2:0] sel = '0;
  logic [PIN_W-1:0] pin_low = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] scr [NUM_SCRATCH];
  logic [DATA_W-1:0] r;
  logic [IRQ_W-1:0] irq;
  logic [IRQ_W-1:0] irq_en;
  logic [PIN_W-1:0] pin_n;
  pmwc_wake_t wsrc;
  pmwc_state_t mode;
  pmwc_gate_t gate;
  logic wake;
  logic rst_req;
  int n_mismatch = 0;
  int cmp_count = 0;

  initial begin
    forever #50 clk = ~clk;
  end

  pmwc_partner i_partner (.sel_i(sel), .fire_i(fire), .drop_i(drop), .pin_low_i(pin_low),
    .core_irq_o(irq), .core_irq_en_o(irq_en), .wake_o(wsrc), .wake_pin_n_o(pin_n));

  // Clock enable held high: freezing is outside what this bench explores
  pmwc_ctrl i_dut (.clk_i(clk), .resetn_i(resetn), .en_i(1'b1), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .wfi_i(wait_for_interrupt), .deep_sleep_select_i(dss),
    .core_irq_i(irq), .core_irq_en_i(irq_en), .wake_src_i(wsrc), .wake_pin_n_i(pin_n),
    .mode_o(mode), .gate_o(gate), .wake_o(wake), .sys_reset_req_o(rst_req));

  task automatic results();
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(nm, exp, rdata);
  endtask

  function automatic pmwc_state_t exp_state(input logic [2:0] pm, input logic ds, input logic blk);
    if (!ds) return ST_SLEEP;
    case (pm)
      PM_DSLEEP: return ST_DSLEEP;
      PM_PDOWN: return ST_PDOWN;
      PM_DPD: return blk ? ST_SLEEP : ST_DPD;
      default: return ST_SLEEP;
    endcase
  endfunction

  // Gate order: core clock, system clock, flash, deep power-down
  function automatic logic [3:0] exp_gate(input pmwc_state_t st);
    case (st)
      ST_SLEEP: return 4'h8;
      ST_DSLEEP: return 4'hc;
      ST_PDOWN: return 4'he;
      ST_DPD: return 4'hf;
      default: return 4'h0;
    endcase
  endfunction

  task automatic enter(input logic [2:0] pm, input logic ds, input logic wb);
    blk_set = blk_set | wb;
    wr(POWER_CONTROL_OFF, {28'h0, wb, pm});
    @(posedge clk);
    dss <= ds;
    wait_for_interrupt <= 1'b1;
    @(posedge clk);
    wait_for_interrupt <= 1'b0;
    #1;
    chk("mode", {29'h0, exp_state(pm, ds, blk_set)}, {29'h0, mode});
    chk("gate", {28'h0, exp_gate(exp_state(pm, ds, blk_set))}, {28'h0, gate});
  endtask

  task automatic fire_src(input logic [2:0] s, input logic dr, input logic ew);
    @(posedge clk);
    sel <= s;
    drop <= dr;
    fire <= 1'b1;
    @(posedge clk);
    #1;
    chk("wake", {31'h0, ew}, {31'h0, wake});
    if (ew) chk("mode", {29'h0, ST_ACTIVE}, {29'h0, mode});
    if (ew) chk("gate", 32'h0, {28'h0, gate});
    @(posedge clk);
    fire <= 1'b0;
    drop <= 1'b0;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    results();
  end

  initial begin
    void'($urandom(32'hb7a9aaa4));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd(POWER_CONTROL_OFF, 32'h0, "power_control");
    for (int i = 0; i < NUM_SCRATCH; i++) rd(SCRATCH_OFF[i], 32'h0, "retained_scratch");
    rd(WAKE_PIN_STATUS_OFF, 32'h0, "wake_pin_status");
    rd(WAKE_PIN_ENABLE_OFF, 32'h0, "wake_pin_enable");
    for (int i = 0; i < NUM_SCRATCH; i++) begin
      scr[i] = $urandom();
      wr(SCRATCH_OFF[i], scr[i]);
    end
    for (int i = 0; i < NUM_SCRATCH; i++) rd(SCRATCH_OFF[i], scr[i], "retained_scratch");
    r = $urandom();
    wr(WAKE_PIN_ENABLE_OFF, r);
    rd(WAKE_PIN_ENABLE_OFF, {24'h0, r[7:0]}, "wake_pin_enable");
    wr(8'h18, 32'hffff_ffff);
    rd(8'h18, 32'h0, "unmapped");
    enter(PM_ACTIVE, 1'b0, 1'b0);
    wr(POWER_CONTROL_OFF, 32'h0);
    rd(POWER_CONTROL_OFF, 32'h100, "power_control");
    fire_src(3'h7, 1'b1, 1'b0);
    fire_src(3'h7, 1'b0, 1'b1);
    wr(POWER_CONTROL_OFF, 32'h100);
    rd(POWER_CONTROL_OFF, 32'h0, "power_control");
    for (int s = 0; s < 7; s++) begin
      enter(3'(1 + s % 2), 1'b1, 1'b0);
      fire_src(3'(s), 1'b1, 1'b0);
      fire_src(3'(s), 1'b0, 1'b1);
    end
    enter(PM_PDOWN, 1'b1, 1'b0);
    fire_src(3'h7, 1'b0, 1'b0);
    fire_src(3'h0, 1'b0, 1'b1);
    enter(3'(4 + $urandom_range(3)), 1'b1, 1'b0);
    fire_src(3'h7, 1'b0, 1'b1);
    wr(POWER_CONTROL_OFF, 32'h100);
    wr(WAKE_PIN_ENABLE_OFF, 32'h02);
    enter(PM_DPD, 1'b1, 1'b0);
    rd(POWER_CONTROL_OFF, 32'h803, "power_control");
    fire_src(3'h1, 1'b0, 1'b0);
    @(posedge clk);
    pin_low <= 8'h01;
    repeat (2) @(posedge clk);
    #1;
    chk("sys_reset_req", 32'h0, {31'h0, rst_req});
    @(posedge clk);
    pin_low <= 8'h03;
    @(posedge clk);
    #1;
    chk("sys_reset_req", 32'h1, {31'h0, rst_req});
    @(posedge clk);
    #1;
    chk("wake", 32'h1, {31'h0, wake});
    rd(SCRATCH_OFF[4], scr[4], "retained_scratch");
    rd(WAKE_PIN_STATUS_OFF, 32'h03, "wake_pin_status");
    @(posedge clk);
    pin_low <= 8'h00;
    wr(WAKE_PIN_STATUS_OFF, 32'h03);
    rd(WAKE_PIN_STATUS_OFF, 32'h0, "wake_pin_status");
    wr(POWER_CONTROL_OFF, 32'h800);
    rd(POWER_CONTROL_OFF, 32'h0, "power_control");
    enter(PM_DPD, 1'b1, 1'b1);
    fire_src(3'h7, 1'b0, 1'b1);
    enter(PM_DPD, 1'b1, 1'b0);
    fire_src(3'h7, 1'b0, 1'b1);
    rd(POWER_CONTROL_OFF, 32'h10b, "power_control");
    results();
  end
endmodule
`default_nettype wire

// >>> verif/pmwc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pmwc_partner
  import pmwc_pkg::*;
(
  input wire logic [2:0] sel_i,
  input wire logic fire_i,
  input wire logic drop_i,
  input wire logic [PIN_W-1:0] pin_low_i,
  output logic [IRQ_W-1:0] core_irq_o,
  output logic [IRQ_W-1:0] core_irq_en_o,
  output pmwc_wake_t wake_o,
  output logic [PIN_W-1:0] wake_pin_n_o
);
  // Pins are pulled up, so a released pin reads high
  assign wake_pin_n_o = ~pin_low_i;
  always_comb begin
    // Timer clocked and loaded, serial slave clocked externally: all qualifiers set up front
    wake_o = '1;
    wake_o.pin_irq = '0;
    {wake_o.bod_irq, wake_o.bod_rst, wake_o.wdt_irq, wake_o.wdt_rst, wake_o.wkt_irq, wake_o.ser_irq} = '0;
    core_irq_o = '0;
    core_irq_en_o = '1;
    if (fire_i) begin
      case (sel_i)
        3'h0: wake_o.pin_irq = 8'h01;
        3'h1: wake_o.bod_irq = 1'b1;
        3'h2: wake_o.bod_rst = 1'b1;
        3'h3: wake_o.wdt_irq = 1'b1;
        3'h4: wake_o.wdt_rst = 1'b1;
        3'h5: wake_o.wkt_irq = 1'b1;
        3'h6: wake_o.ser_irq = 1'b1;
        default: core_irq_o = 32'h0000_0010;
      endcase
    end
    // Drop one qualifier only, so a wake that ignores it shows up
    if (drop_i) begin
      case (sel_i)
        3'h0: wake_o.pin_start = '0;
        3'h1: wake_o.bod_powered = 1'b0;
        3'h2: wake_o.bod_rst_en = 1'b0;
        3'h3: wake_o.wdt_running = 1'b0;
        3'h4: wake_o.low_power_oscillator_powered = 1'b0;
        3'h5: wake_o.wkt_start = 1'b0;
        3'h6: wake_o.ser_core_interrupt_controller_en = 1'b0;
        default: core_irq_en_o = '0;
      endcase
    end
  end
endmodule
`default_nettype wire
